// file: pkg/dcw_pkg.sv
`default_nettype none
package dcw_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] DCW_ADDR_CMD    = 16'h6040;
  localparam logic [15:0] DCW_ADDR_STATE  = 16'h6041;
  localparam logic [15:0] DCW_ADDR_MODE   = 16'h6060;
  localparam logic [15:0] DCW_ADDR_ACTIVE = 16'h5ff0;
  localparam logic [15:0] DCW_ADDR_RESUME = 16'h5ff1;
  localparam logic [15:0] DCW_ADDR_TGT    = 16'h5e00;
  localparam logic [15:0] DCW_ADDR_NEXT   = 16'h5e20;

  // ************************************************************
  // Values and field positions
  // ************************************************************
  localparam logic [7:0]  DCW_MODE_CSV   = 8'h09;
  localparam logic [7:0]  DCW_MODE_TABLE = 8'hff;
  localparam logic [15:0] DCW_CMD_RST    = 16'h0000;
  localparam logic [7:0]  DCW_MODE_RST   = 8'h00;
  localparam logic [15:0] DCW_SW_SOD     = 16'h0050;
  localparam logic [15:0] DCW_SW_RDY     = 16'h0031;
  localparam logic [15:0] DCW_SW_SON     = 16'h0033;
  localparam logic [7:0]  DCW_SW_OPEN    = 8'h37;
  localparam logic [7:0]  DCW_SW_FAULT   = 8'h18;
  localparam logic [15:0] DCW_NO_RESUME  = 16'hffff;
  localparam int CB_SEQ   = 4;
  localparam int CB_RES   = 6;
  localparam int CB_FRST  = 7;
  localparam int CB_HALT  = 8;
  localparam int CB_START = 9;
  localparam int CB_SEL   = 11;
  localparam int SB_PROG  = 8;
  localparam int SB_REM   = 9;
  localparam int SB_TGT   = 10;
  localparam int SB_LIM   = 11;
  localparam int SB_GEAR  = 12;
  localparam int SB_FOLL  = 13;
  localparam int SB_WARN2 = 15;
  localparam int DCW_BLOCKS = 32;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_SOD  = 3'b000,
    ST_RDY  = 3'b001,
    ST_SON  = 3'b011,
    ST_OPEN = 3'b010,
    ST_FLT  = 3'b110
  } dcw_state_t;

  typedef struct packed {
    logic block_done;
    logic axis_stopped;
    logic target_hit;
    logic in_gear;
    logic limit;
    logic follow_err;
    logic remote;
    logic warn;
    logic warn2;
    logic fault;
  } dcw_motion_in_t;

  typedef struct packed {
    logic        vel_run;
    logic        move_run;
    logic        halt_ramp;
    logic        launch;
    logic [5:0]  active_block;
    logic [15:0] target_pos;
  } dcw_motion_out_t;

  typedef struct packed {
    dcw_state_t      st;
    logic [15:0]     cmd;
    logic [7:0]      mode;
    logic            start_prev;
    logic            frst_prev;
    logic            progress;
    logic            auto_seq;
    logic            resume_ok;
    logic [5:0]      active;
    logic [5:0]      resume_blk;
    logic [15:0]     status;
    logic [15:0]     rdata;
    dcw_motion_out_t mo;
  } dcw_regs_t;

endpackage
`default_nettype wire

// file: src/dcw_top.sv
`default_nettype none
module dcw_top #(
  parameter int BLOCKS = 32
) (
  // Clock and reset
  input  wire logic                     CORE_CLK,
  input  wire logic                     SRST,
  // Register port
  input  wire logic [15:0]              REG_ADDR,
  input  wire logic [15:0]              REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output var  logic [15:0]              REG_RDATA,
  // Motion engine
  input  wire dcw_pkg::dcw_motion_in_t  MOTION_IN,
  output var  dcw_pkg::dcw_motion_out_t MOTION_OUT
);
  import dcw_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [5:0] sel_block(input logic [15:0] c);
    sel_block = {1'b0, c[15:CB_SEL]} + 6'h01;
  endfunction

  function automatic logic [4:0] blk_idx(input logic [5:0] b);
    blk_idx = 5'(b - 6'h01);
  endfunction

  // Zero and the three error stops end a chain; other negatives too, to stay safe
  function automatic logic chain_end(input logic [7:0] nb);
    chain_end = nb[7] || (nb == 8'h00) || (nb > 8'(BLOCKS));
  endfunction

  // ************************************************************
  // Motion block table
  // ************************************************************
  logic [15:0] tgt_tab  [BLOCKS];
  logic [7:0]  next_tab [BLOCKS];

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      for (int i = 0; i < BLOCKS; i++) begin
        tgt_tab[i]  <= 16'h0000;
        next_tab[i] <= 8'h00;
      end
    end else if (REG_WR) begin
      if (REG_ADDR[15:5] == DCW_ADDR_TGT[15:5]) begin
        tgt_tab[REG_ADDR[4:0]] <= REG_WDATA;
      end
      if (REG_ADDR[15:5] == DCW_ADDR_NEXT[15:5]) begin
        next_tab[REG_ADDR[4:0]] <= REG_WDATA[7:0];
      end
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  dcw_regs_t r;
  dcw_regs_t n;
  logic      tbl;
  logic      edge_start;
  logic      kill;
  logic [7:0] nxt;
  logic [5:0] blk;

  assign tbl        = (r.st == ST_OPEN) && (r.mode == DCW_MODE_TABLE);
  assign edge_start = r.cmd[CB_START] && !r.start_prev;
  assign kill       = !r.cmd[1] || !r.cmd[2];
  assign nxt        = next_tab[blk_idx(r.active)];

  always_comb begin
    n = r;
    n.mo.launch = 1'b0;
    n.frst_prev = r.cmd[CB_FRST];
    n.start_prev = r.cmd[CB_START];
    blk = sel_block(r.cmd);
    // Software writes; the host keeps mode changes to safe states
    if (REG_WR) begin
      case (REG_ADDR)
        DCW_ADDR_CMD:  n.cmd = REG_WDATA;
        DCW_ADDR_MODE: n.mode = REG_WDATA[7:0];
        default: ;
      endcase
    end
    // Device state machine on the held command word
    if (MOTION_IN.fault && r.st != ST_FLT) begin
      n.st = ST_FLT;
    end else begin
      case (r.st)
        ST_SOD:  if (r.cmd[2:0] == 3'b110) n.st = ST_RDY;
        ST_RDY: begin
          if (kill) n.st = ST_SOD;
          else if (r.cmd[0]) n.st = ST_SON;
        end
        ST_SON: begin
          if (kill) n.st = ST_SOD;
          else if (!r.cmd[0]) n.st = ST_RDY;
          else if (r.cmd[3]) n.st = ST_OPEN;
        end
        ST_OPEN: begin
          if (kill) n.st = ST_SOD;
          else if (!r.cmd[0]) n.st = ST_RDY;
          else if (!r.cmd[3]) n.st = ST_SON;
        end
        ST_FLT: begin
          if (r.cmd[CB_FRST] && !r.frst_prev && !MOTION_IN.fault) n.st = ST_SOD;
        end
        default: n.st = ST_SOD;
      endcase
    end
    // Table travel sequencing; bits 5 and 10 are never looked at
    if (tbl) begin
      if (edge_start && !r.cmd[CB_HALT]) begin
        n.active = (r.cmd[CB_RES] && r.resume_ok) ? r.resume_blk : blk;
        n.progress = 1'b1;
        n.auto_seq = r.cmd[CB_SEQ];
        n.resume_ok = 1'b0;
        n.mo.launch = 1'b1;
      end else if (!r.cmd[CB_START] && r.progress) begin
        n.progress = 1'b0;
        n.resume_ok = 1'b1;
        n.resume_blk = r.active;
      end else if (MOTION_IN.block_done && r.progress && !r.cmd[CB_HALT]) begin
        if (!r.auto_seq || chain_end(nxt)) begin
          n.progress = 1'b0;
        end else begin
          n.active = nxt[5:0];
          n.mo.launch = 1'b1;
        end
      end
    end else if (r.progress) begin
      // Leaving table travel mid-move leaves the block resumable
      n.progress = 1'b0;
      n.resume_ok = 1'b1;
      n.resume_blk = r.active;
    end
    // State word
    case (n.st)
      ST_SOD:  n.status = DCW_SW_SOD;
      ST_RDY:  n.status = DCW_SW_RDY;
      ST_SON:  n.status = DCW_SW_SON;
      ST_OPEN: n.status = {8'h00, DCW_SW_OPEN};
      default: n.status = {8'h00, DCW_SW_FAULT};
    endcase
    n.status[7] = MOTION_IN.warn;
    n.status[SB_REM] = MOTION_IN.remote;
    n.status[SB_LIM] = MOTION_IN.limit;
    n.status[SB_FOLL] = MOTION_IN.follow_err;
    n.status[SB_WARN2] = MOTION_IN.warn2;
    if (r.mode == DCW_MODE_TABLE) begin
      n.status[SB_PROG] = n.progress;
      n.status[SB_TGT] = r.cmd[CB_HALT] ? MOTION_IN.axis_stopped : MOTION_IN.target_hit;
      n.status[SB_GEAR] = MOTION_IN.in_gear;
    end else begin
      n.status[SB_GEAR] = (n.st == ST_OPEN) && (r.mode == DCW_MODE_CSV);
    end
    n.status[14] = 1'b0;
    // Outputs to the motion engine
    n.mo.vel_run = (n.st == ST_OPEN) && (n.mode == DCW_MODE_CSV);
    n.mo.move_run = n.progress && !r.cmd[CB_HALT];
    n.mo.halt_ramp = tbl && r.cmd[CB_HALT];
    n.mo.active_block = n.active;
    n.mo.target_pos = tgt_tab[blk_idx(n.active)];
    // Read data stands only in the cycle after the strobe
    n.rdata = 16'h0000;
    if (REG_RD) begin
      if (REG_ADDR[15:5] == DCW_ADDR_TGT[15:5]) begin
        n.rdata = tgt_tab[REG_ADDR[4:0]];
      end else if (REG_ADDR[15:5] == DCW_ADDR_NEXT[15:5]) begin
        n.rdata = {{8{next_tab[REG_ADDR[4:0]][7]}}, next_tab[REG_ADDR[4:0]]};
      end else begin
        case (REG_ADDR)
          DCW_ADDR_CMD:    n.rdata = r.cmd;
          DCW_ADDR_STATE:  n.rdata = r.status;
          DCW_ADDR_MODE:   n.rdata = {8'h00, r.mode};
          DCW_ADDR_ACTIVE: n.rdata = {10'h000, r.active};
          DCW_ADDR_RESUME: n.rdata = r.resume_ok ? {10'h000, r.resume_blk} : DCW_NO_RESUME;
          default:         n.rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      r <= '0;
      r.st <= ST_SOD;
      r.cmd <= DCW_CMD_RST;
      r.mode <= DCW_MODE_RST;
      r.status <= DCW_SW_SOD;
    end else begin
      r <= n;
    end
  end

  assign REG_RDATA  = r.rdata;
  assign MOTION_OUT = r.mo;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  sequence s_table_launch;
    tbl && edge_start && !r.cmd[CB_HALT] && !kill && r.cmd[0] && r.cmd[3] && !MOTION_IN.fault;
  endsequence

  sequence s_held_open;
    !kill && r.cmd[0] && r.cmd[3] && !MOTION_IN.fault;
  endsequence

  sequence s_chain_step;
    tbl && r.progress && r.auto_seq && MOTION_IN.block_done && r.cmd[CB_START]
      && !r.cmd[CB_HALT] ##0 s_held_open;
  endsequence

  sequence s_switch_on;
    r.st == ST_RDY && !kill && r.cmd[0] && !MOTION_IN.fault;
  endsequence

  a_sod_word: assert property (r.st == ST_SOD |-> r.status[6:0] == DCW_SW_SOD[6:0])
    else $error("switch-on-disabled word wrong");
  a_son_word: assert property (r.st == ST_SON |-> r.status[6:0] == DCW_SW_SON[6:0])
    else $error("switched-on word wrong");
  a_open_low: assert property (r.st == ST_OPEN |-> r.status[6:0] == DCW_SW_OPEN[6:0])
    else $error("operation-enabled word wrong");
  a_stop_seven: assert property (r.st == ST_OPEN && r.cmd == 16'h0007
      && !MOTION_IN.fault |=> r.st == ST_SON && !MOTION_OUT.vel_run)
    else $error("0x0007 did not stop operation");
  a_csv_run: assert property (r.st == ST_OPEN && r.mode == DCW_MODE_CSV
      |-> MOTION_OUT.vel_run)
    else $error("velocity mode not running");
  a_launch_edge: assert property (s_table_launch |=> r.progress && MOTION_OUT.launch)
    else $error("start edge did not launch");
  a_select_blk: assert property (s_table_launch ##0 !r.cmd[CB_RES]
      |=> r.active == $past(blk))
    else $error("wrong block selected");
  a_resume_blk: assert property (s_table_launch ##0 r.cmd[CB_RES] && r.resume_ok
      |=> r.active == $past(r.resume_blk))
    else $error("resume block not used");
  a_drop_start: assert property (r.progress && !r.cmd[CB_START]
      |=> !r.progress && r.resume_ok)
    else $error("dropped start did not stop");
  a_single_done: assert property (tbl && r.progress && !r.auto_seq
      && MOTION_IN.block_done && r.cmd[CB_START] && !r.cmd[CB_HALT] ##0 s_held_open
      |=> !r.progress)
    else $error("single block did not finish");
  a_halt_reach: assert property (r.mode == DCW_MODE_TABLE && r.cmd[CB_HALT]
      && MOTION_IN.axis_stopped |=> r.status[SB_TGT])
    else $error("halt target flag missing");
  a_halt_stays: assert property (tbl && r.cmd[CB_HALT] ##0 s_held_open
      |=> r.st == ST_OPEN && MOTION_OUT.halt_ramp)
    else $error("halt left operation enabled");
  a_bit14_zero: assert property (r.status[14] == 1'b0)
    else $error("state bit 14 set");
  a_rdy_word: assert property (r.st == ST_RDY |-> r.status[6:0] == DCW_SW_RDY[6:0])
    else $error("ready-to-switch-on word wrong");
  a_flt_word: assert property (r.st == ST_FLT |-> r.status[6:0] == DCW_SW_FAULT[6:0])
    else $error("fault word wrong");
  a_shut_step: assert property (r.st == ST_SOD && r.cmd[2:0] == 3'b110
      && !MOTION_IN.fault |=> r.st == ST_RDY)
    else $error("shutdown command not taken");
  a_switch_on: assert property (s_switch_on |=> r.st == ST_SON)
    else $error("switch-on command not taken");
  a_enable_op: assert property (r.st == ST_SON ##0 s_held_open |=> r.st == ST_OPEN)
    else $error("enable command not taken");
  a_son_back: assert property (r.st == ST_OPEN && !kill && !r.cmd[0]
      && !MOTION_IN.fault |=> r.st == ST_RDY)
    else $error("switch-on drop ignored");
  a_quick_stop: assert property (r.st != ST_FLT && kill && !MOTION_IN.fault
      |=> r.st == ST_SOD)
    else $error("voltage or quick stop drop ignored");
  a_flt_entry: assert property (MOTION_IN.fault |=> r.st == ST_FLT)
    else $error("fault not entered");
  a_flt_clear: assert property (r.st == ST_FLT && r.cmd[CB_FRST] && !r.frst_prev
      && !MOTION_IN.fault |=> r.st == ST_SOD)
    else $error("fault reset edge ignored");
  a_csv_start: assert property (r.st == ST_SON ##0 s_held_open
      ##0 r.mode == DCW_MODE_CSV && !(REG_WR && REG_ADDR == DCW_ADDR_MODE)
      |=> MOTION_OUT.vel_run)
    else $error("velocity mode did not start");
  a_table_only: assert property (!tbl |=> !MOTION_OUT.launch)
    else $error("launch outside table travel");
  a_halt_hold: assert property (tbl && r.cmd[CB_HALT] |=> !MOTION_OUT.launch)
    else $error("launch while halted");
  a_halt_still: assert property (r.cmd[CB_HALT] |=> !MOTION_OUT.move_run)
    else $error("axis moving under halt");
  a_chain_next: assert property (s_chain_step ##0 !chain_end(nxt)
      |=> r.active == $past(nxt[5:0]) && MOTION_OUT.launch)
    else $error("chain did not advance");
  a_chain_end: assert property (s_chain_step ##0 chain_end(nxt) |=> !r.progress)
    else $error("chain did not end");
  a_block_range: assert property (MOTION_OUT.launch
      |-> MOTION_OUT.active_block != 6'h00 && MOTION_OUT.active_block <= 6'(BLOCKS))
    else $error("launched block out of range");
  a_prog_flag: assert property (r.mode == DCW_MODE_TABLE
      |=> r.status[SB_PROG] == r.progress)
    else $error("progress flag not reported");
  a_reach_flag: assert property (r.mode == DCW_MODE_TABLE && !r.cmd[CB_HALT]
      |=> r.status[SB_TGT] == $past(MOTION_IN.target_hit))
    else $error("target reached flag wrong");
  a_mirror_bits: assert property (1'b1
      |=> r.status[SB_REM] == $past(MOTION_IN.remote)
      && r.status[SB_LIM] == $past(MOTION_IN.limit)
      && r.status[SB_FOLL] == $past(MOTION_IN.follow_err)
      && r.status[SB_WARN2] == $past(MOTION_IN.warn2))
    else $error("mirrored state bits wrong");
  a_warn_bit: assert property (1'b1 |=> r.status[7] == $past(MOTION_IN.warn))
    else $error("warning bit wrong");
  a_rd_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data stands too long");
  a_state_read: assert property (REG_RD && REG_ADDR == DCW_ADDR_STATE
      |=> REG_RDATA == $past(r.status))
    else $error("state word read wrong");
  a_mode_write: assert property (REG_WR && REG_ADDR == DCW_ADDR_MODE
      |=> r.mode == $past(REG_WDATA[7:0]))
    else $error("mode write lost");

endmodule
`default_nettype wire

// file: testbench/dcw_motion_model.sv
`default_nettype none
module dcw_motion_model
  import dcw_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Engine side
  input  wire dcw_motion_out_t mo,
  input  wire logic            slow,
  output logic                 done,
  output logic                 stopped,
  output logic                 hit
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Block engine
  // ************************************************************
  logic [5:0] cnt;
  // Axis speed is zero whenever no block is moving
  assign stopped = !mo.move_run;
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      cnt <= 6'h00;
      hit <= 1'b0;
    end else if (mo.launch) begin
      cnt <= slow ? 6'h14 : 6'h02;
      hit <= 1'b0;
    end else if (!mo.move_run) begin
      // Halt or start low ramps down; the block never completes
      cnt <= 6'h00;
    end else if (cnt == 6'h01) begin
      cnt  <= 6'h00;
      done <= 1'b1;
      hit  <= 1'b1;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcw_pkg::*;
  logic            clk;
  logic            srst;
  logic [15:0]     addr;
  logic [15:0]     wdata;
  logic            wr;
  logic            rd;
  logic [15:0]     rdata;
  logic            slow;
  logic [6:0]      fl;
  logic            done;
  logic            stp;
  logic            hit;
  logic [5:0]      last_blk;
  logic [15:0]     last_tgt;
  logic [4:0]      n;
  logic [15:0]     tv;
  logic [15:0]     c;
  logic [7:0]      endv [4] = '{8'h00, 8'hff, 8'hfe, 8'hfd};
  logic [4:0]      corner [4] = '{5'd0, 5'd3, 5'd16, 5'd31};
  dcw_motion_in_t  mi;
  dcw_motion_out_t mo;
  int              fail_count;
  int              cmp_count;
  int              launches;
  int              cyc;
  assign mi = '{block_done: done, axis_stopped: stp, target_hit: hit, in_gear: fl[0],
                limit: fl[1], follow_err: fl[2], remote: fl[3], warn: fl[4], warn2: fl[5],
                fault: fl[6]};
  dcw_top #(.BLOCKS(32)) u_dut (.CORE_CLK(clk), .SRST(srst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MOTION_IN(mi),
    .MOTION_OUT(mo));
  dcw_motion_model u_eng (.clk(clk), .rst(srst), .mo(mo), .slow(slow), .done(done),
    .stopped(stp), .hit(hit));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (mo.launch === 1'b1) begin
      launches++;
      last_blk <= mo.active_block;
      last_tgt <= mo.target_pos;
    end
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] sw(input logic [7:0] lo, input logic p, input logic t);
    return {fl[5], 1'b0, fl[2], fl[0], fl[1], t, fl[3], p, lo | {fl[4], 7'h00}};
  endfunction
  task automatic cmp(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] a, input logic [15:0] e,
                     input logic [15:0] m = 16'hffff);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    cmp(nm, rdata & m, e);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    srst = 1'b1; addr = 16'h0000; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
    slow = 1'b0; fl = 7'h00; last_blk = 6'h00; last_tgt = 16'h0000;
    void'($urandom(32'he452));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    chk("state", DCW_ADDR_STATE, DCW_SW_SOD);
    chk("mode", DCW_ADDR_MODE, 16'h0000);
    wr16(16'h1234, 16'hffff);
    chk("unmapped", 16'h1234, 16'h0000);
    $display("test reset done");
    wr16(DCW_ADDR_CMD, 16'h0000);
    chk("state", DCW_ADDR_STATE, DCW_SW_SOD);
    wr16(DCW_ADDR_MODE, {8'h00, DCW_MODE_CSV});
    wr16(DCW_ADDR_CMD, 16'h0006);
    chk("state", DCW_ADDR_STATE, DCW_SW_RDY);
    wr16(DCW_ADDR_CMD, 16'h0007);
    chk("state", DCW_ADDR_STATE, DCW_SW_SON);
    wr16(DCW_ADDR_CMD, 16'h000f);
    chk("state", DCW_ADDR_STATE, sw(DCW_SW_OPEN, 1'b0, 1'b0) | 16'h1000);
    cmp("vel_run", {15'h0000, mo.vel_run}, 16'h0001);
    wr16(DCW_ADDR_CMD, 16'h0007);
    cmp("vel_run", {15'h0000, mo.vel_run}, 16'h0000);
    chk("state", DCW_ADDR_STATE, DCW_SW_SON);
    wr16(DCW_ADDR_CMD, 16'h000f);
    cmp("vel_run", {15'h0000, mo.vel_run}, 16'h0001);
    // Host drops back to switched on before touching the mode
    wr16(DCW_ADDR_CMD, 16'h0007);
    wr16(DCW_ADDR_MODE, {8'h00, DCW_MODE_TABLE});
    chk("mode", DCW_ADDR_MODE, 16'h00ff);
    wr16(DCW_ADDR_CMD, 16'h000f);
    cmp("vel_run", {15'h0000, mo.vel_run}, 16'h0000);
    chk("state", DCW_ADDR_STATE, 16'h0037);
    $display("test enable done");
    slow <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      n  = (i < 4) ? corner[i] : 5'($urandom_range(31));
      tv = 16'($urandom);
      fl <= 7'($urandom_range(63));
      c  = {n, 11'h00f} | (16'h0420 & 16'($urandom));
      wr16(DCW_ADDR_TGT + 16'(n), tv);
      wr16(DCW_ADDR_CMD, c);
      launches = 0;
      wr16(DCW_ADDR_CMD, c | 16'h0200);
      cmp("launches", 16'(launches), 16'h0001);
      cmp("block", {10'h000, last_blk}, {10'h000, 6'(n) + 6'h01});
      cmp("target", last_tgt, tv);
      chk("state", DCW_ADDR_STATE, sw(DCW_SW_OPEN, 1'b1, 1'b0));
      repeat (30) @(posedge clk);
      chk("state", DCW_ADDR_STATE, sw(DCW_SW_OPEN, 1'b0, 1'b1));
    end
    $display("test select done");
    slow <= 1'b0;
    fl <= 7'h00;
    wr16(DCW_ADDR_NEXT, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      wr16(DCW_ADDR_NEXT + 16'h0001, {8'h00, endv[k]});
      chk("next", DCW_ADDR_NEXT + 16'h0001, {{8{endv[k][7]}}, endv[k]});
      wr16(DCW_ADDR_CMD, 16'h001f);
      launches = 0;
      wr16(DCW_ADDR_CMD, 16'h021f);
      repeat (20) @(posedge clk);
      cmp("launches", 16'(launches), 16'h0002);
      cmp("block", {10'h000, last_blk}, 16'h0002);
      chk("state", DCW_ADDR_STATE, sw(DCW_SW_OPEN, 1'b0, 1'b1));
    end
    $display("test chain done");
    slow <= 1'b1;
    wr16(DCW_ADDR_CMD, 16'h000f);
    wr16(DCW_ADDR_CMD, 16'h020f);
    wr16(DCW_ADDR_CMD, 16'h030f);
    cmp("halt", {14'h0000, mo.halt_ramp, mo.move_run}, 16'h0002);
    chk("state", DCW_ADDR_STATE, sw(DCW_SW_OPEN, 1'b1, 1'b1));
    wr16(DCW_ADDR_CMD, 16'h020f);
    cmp("move", {15'h0000, mo.move_run}, 16'h0001);
    wr16(DCW_ADDR_CMD, 16'h000f);
    cmp("move", {15'h0000, mo.move_run}, 16'h0000);
    chk("resume", DCW_ADDR_RESUME, 16'h0001);
    wr16(DCW_ADDR_CMD, 16'h284f);
    wr16(DCW_ADDR_CMD, 16'h2a4f);
    cmp("block", {10'h000, last_blk}, 16'h0001);
    chk("active", DCW_ADDR_ACTIVE, 16'h0001);
    repeat (30) @(posedge clk);
    chk("resume", DCW_ADDR_RESUME, DCW_NO_RESUME);
    wr16(DCW_ADDR_CMD, 16'h284f);
    wr16(DCW_ADDR_CMD, 16'h2a4f);
    cmp("block", {10'h000, last_blk}, 16'h0006);
    repeat (30) @(posedge clk);
    $display("test halt resume done");
    fl <= 7'h40;
    repeat (3) @(posedge clk);
    chk("state", DCW_ADDR_STATE, {8'h00, DCW_SW_FAULT}, 16'h00ff);
    fl <= 7'h00;
    wr16(DCW_ADDR_CMD, 16'h0080);
    chk("state", DCW_ADDR_STATE, 16'h0050, 16'h00ff);
    wr16(DCW_ADDR_CMD, 16'h0006);
    chk("state", DCW_ADDR_STATE, 16'h0031, 16'h00ff);
    wr16(DCW_ADDR_CMD, 16'h0002);
    chk("state", DCW_ADDR_STATE, 16'h0050, 16'h00ff);
    $display("test fault done");
    end_sim();
  end
endmodule
`default_nettype wire
